// File: design/snc_pkg.sv
// package of encodings, widths and reset values for the stack/negate/call decoder
// Summary of operation
// - negate opcode writes two's complement back
// - negate updates N, OV, C, DC, Z
// - access bit clear selects access bank
// - extended set, a clear, f<=95: indexed mode
// - discard opcode drops top stack entry
// - push opcode stacks program counter plus two
// - old top moves one level down, except when a push wraps a full stack
// - relative call carries 11-bit signed offset
// - call pushes return, jumps pc+2+2n
// - relative call takes two cycles
package snc_pkg;
  localparam int PC_W = 21;
  localparam int STK_DEPTH = 31;
  localparam int SP_W = 5;
  localparam logic [15:0] OP_DISCARD = 16'h0006;
  localparam logic [15:0] OP_PUSH = 16'h0005;
  localparam logic [15:0] OP_SWRESET = 16'h00FF;
  localparam logic [6:0] OP_NEG_HI = 7'h36;
  localparam logic [4:0] OP_CALL_HI = 5'h1B;
  localparam logic [7:0] IDX_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam int FL_C = 0;
  localparam int FL_DC = 1;
  localparam int FL_Z = 2;
  localparam int FL_OV = 3;
  localparam int FL_N = 4;
  typedef enum logic [1:0] {
    SNC_EXEC = 2'b00,
    SNC_FLUSH = 2'b01
  } snc_state_t;
endpackage

// File: design/snc_negate_unit.sv
// byte negate datapath with status flag generation
module snc_negate_unit (
  input wire logic [7:0] operand,
  output logic [7:0] result,
  output logic [4:0] flags
);
  logic [8:0] sum;
  logic [4:0] low_sum;
  // 0 - f computed as ~f + 1 so carry means no borrow
  always_comb begin
    sum = {1'b0, ~operand} + 9'h001;
    low_sum = {1'b0, ~operand[3:0]} + 5'h01;
    result = sum[7:0];
    flags = 5'h00;
    flags[snc_pkg::FL_C] = sum[8];
    flags[snc_pkg::FL_DC] = low_sum[4];
    flags[snc_pkg::FL_Z] = (sum[7:0] == 8'h00);
    flags[snc_pkg::FL_N] = sum[7];
    flags[snc_pkg::FL_OV] = (operand == 8'h80); // only -128 overflows
  end
endmodule

// File: design/snc_core.sv
// decode and execute of negate, stack discard/push, relative call, software reset
module snc_core (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire logic ext_set_en,
  input wire logic [3:0] bank_sel_in,
  input wire logic [7:0] mem_rdata,
  output logic [11:0] mem_addr,
  output logic mem_indexed,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  output logic [snc_pkg::PC_W-1:0] pc,
  output logic [snc_pkg::PC_W-1:0] stack_top,
  output logic [snc_pkg::SP_W-1:0] stack_ptr,
  output logic [4:0] status_flags,
  output logic instr_ready,
  output logic sw_reset_pulse
);
  logic [snc_pkg::PC_W-1:0] pc_ff;
  logic [snc_pkg::PC_W-1:0] stack_mem [snc_pkg::STK_DEPTH];
  logic [snc_pkg::SP_W-1:0] sp_ff;
  logic [4:0] flags_ff;
  logic [7:0] neg_result;
  logic [4:0] neg_flags;
  logic [snc_pkg::PC_W-1:0] ret_addr;
  logic [snc_pkg::PC_W-1:0] call_target;
  logic [snc_pkg::PC_W-1:0] call_off;
  logic is_neg, is_pop, is_push, is_call, is_rst, take, do_push;
  logic swr_ff;
  snc_pkg::snc_state_t state_ff;
  snc_pkg::snc_state_t nxt_state;

  // opcode match helpers
  function automatic logic match16(input logic [15:0] a, input logic [15:0] b);
    match16 = (a == b);
  endfunction

  // wrapping stack index, used for push and read of top
  function automatic logic [snc_pkg::SP_W-1:0] slot(input logic [snc_pkg::SP_W-1:0] p);
    slot = (p == 5'd0) ? 5'(snc_pkg::STK_DEPTH - 1) : 5'(p - 5'd1);
  endfunction

  snc_negate_unit u_neg (
    .operand(mem_rdata),
    .result(neg_result),
    .flags(neg_flags)
  );

  // decode; second call cycle accepts nothing
  assign instr_ready = (state_ff == snc_pkg::SNC_EXEC);
  assign take = instr_valid && instr_ready;
  assign is_neg = take && (instr[15:9] == snc_pkg::OP_NEG_HI);
  assign is_pop = take && match16(instr, snc_pkg::OP_DISCARD);
  assign is_push = take && match16(instr, snc_pkg::OP_PUSH);
  assign is_call = take && (instr[15:11] == snc_pkg::OP_CALL_HI);
  assign is_rst = take && match16(instr, snc_pkg::OP_SWRESET);
  assign do_push = is_push || is_call;

  // return address and sign-extended doubled offset
  assign ret_addr = pc_ff + snc_pkg::PC_STEP;
  assign call_off = {{(snc_pkg::PC_W - 12){instr[10]}}, instr[10:0], 1'b0};
  assign call_target = ret_addr + call_off;

  // operand address: access bank split or bank register, indexed mode flagged
  always_comb begin
    mem_indexed = 1'b0;
    if (instr[8]) begin
      mem_addr = {bank_sel_in, instr[7:0]};
    end else if (ext_set_en && instr[7:0] <= snc_pkg::IDX_LIMIT) begin
      mem_indexed = 1'b1;
      mem_addr = {4'h0, instr[7:0]};
    end else if (instr[7:0] >= snc_pkg::ACCESS_SPLIT) begin
      mem_addr = {snc_pkg::ACCESS_HI_BANK, instr[7:0]};
    end else begin
      mem_addr = {4'h0, instr[7:0]};
    end
  end

  // write back happens in the same cycle, single cycle op
  assign mem_we = is_neg;
  assign mem_wdata = neg_result;

  // call flush state
  always_comb begin
    nxt_state = snc_pkg::SNC_EXEC;
    if (state_ff == snc_pkg::SNC_EXEC && is_call) begin
      nxt_state = snc_pkg::SNC_FLUSH;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || is_rst) begin
      state_ff <= snc_pkg::SNC_EXEC;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // program counter; software reset restarts from reset vector
  always_ff @(posedge clk) begin
    if (!rstn || is_rst) begin
      pc_ff <= snc_pkg::PC_RESET;
    end else if (is_call) begin
      pc_ff <= call_target;
    end else if (take) begin
      pc_ff <= ret_addr;
    end
  end

  // stack pointer; overflow wraps rather than stalling the core
  always_ff @(posedge clk) begin
    if (!rstn || is_rst) begin
      sp_ff <= 5'd0;
    end else if (do_push) begin
      sp_ff <= (sp_ff == 5'(snc_pkg::STK_DEPTH)) ? 5'd1 : 5'(sp_ff + 5'd1);
    end else if (is_pop) begin
      sp_ff <= (sp_ff == 5'd0) ? 5'd0 : 5'(sp_ff - 5'd1);
    end
  end

  // stack storage; older entries untouched so they remain beneath, except on overflow, where the wrap rewrites the bottom slot
  always_ff @(posedge clk) begin
    if (do_push) begin
      stack_mem[slot(sp_ff == 5'(snc_pkg::STK_DEPTH) ? 5'd1 : 5'(sp_ff + 5'd1))] <= ret_addr;
    end
  end

  // status flags
  always_ff @(posedge clk) begin
    if (!rstn || is_rst) begin
      flags_ff <= snc_pkg::FLAGS_RESET;
    end else if (is_neg) begin
      flags_ff <= neg_flags;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      swr_ff <= 1'b0;
    end else begin
      swr_ff <= is_rst;
    end
  end

  assign pc = pc_ff;
  assign stack_ptr = sp_ff;
  assign stack_top = (sp_ff == 5'd0) ? snc_pkg::PC_RESET : stack_mem[slot(sp_ff)];
  assign status_flags = flags_ff;
  assign sw_reset_pulse = swr_ff;

  // assertions
  logic [snc_pkg::PC_W-1:0] pc_prev;
  always_ff @(posedge clk) begin
    pc_prev <= pc_ff;
  end

  sequence s_call_taken;
    is_call;
  endsequence
  sequence s_flush_cycle;
    !instr_ready ##1 instr_ready;
  endsequence

  a_call_two_cycles: assert property (@(posedge clk) disable iff (!rstn)
    s_call_taken |=> s_flush_cycle)
    else $error("relative call did not take two cycles");
  a_call_pushes_ret: assert property (@(posedge clk) disable iff (!rstn)
    is_call |=> stack_top == $past(ret_addr))
    else $error("call return address wrong");
  a_call_target: assert property (@(posedge clk) disable iff (!rstn)
    is_call |=> pc == $past(call_target))
    else $error("call target wrong");
  a_push_stack_top: assert property (@(posedge clk) disable iff (!rstn)
    is_push |=> stack_top == $past(pc_ff) + snc_pkg::PC_STEP)
    else $error("push did not stack pc plus two");
  a_pop_restores: assert property (@(posedge clk) disable iff (!rstn)
    (is_push && sp_ff != 5'd0 && sp_ff != 5'(snc_pkg::STK_DEPTH)) ##1 is_pop
    |=> stack_top == $past(stack_top, 2))
    else $error("old top not kept beneath push");
  a_pop_drops: assert property (@(posedge clk) disable iff (!rstn)
    (is_pop && sp_ff != 5'd0) |=> sp_ff == $past(sp_ff) - 5'd1)
    else $error("discard did not drop top");
  a_neg_write: assert property (@(posedge clk) disable iff (!rstn)
    is_neg |-> mem_we && mem_wdata == 8'(~mem_rdata + 8'h01))
    else $error("negate result wrong");
  a_neg_zero_flag: assert property (@(posedge clk) disable iff (!rstn)
    is_neg |=> status_flags[snc_pkg::FL_Z] == ($past(mem_rdata) == 8'h00))
    else $error("negate zero flag wrong");
  a_indexed_mode: assert property (@(posedge clk) disable iff (!rstn)
    (is_neg && !instr[8] && ext_set_en && instr[7:0] <= snc_pkg::IDX_LIMIT) |-> mem_indexed)
    else $error("indexed mode not selected");
  a_swreset_state: assert property (@(posedge clk) disable iff (!rstn)
    is_rst |=> pc == snc_pkg::PC_RESET && stack_ptr == 5'd0 && status_flags == 5'h00)
    else $error("software reset incomplete");
  a_single_cycle: assert property (@(posedge clk) disable iff (!rstn)
    (is_neg || is_pop || is_push) |=> instr_ready && pc == pc_prev + snc_pkg::PC_STEP)
    else $error("single cycle op stalled");
endmodule

// File: tb/snc_testbench.sv
// self-checking bench for the stack, negate and call decoder
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, instr_valid = 0, ext_set_en = 0;
  logic [15:0] instr = 16'h0000;
  logic [3:0] bank_sel_in = 4'h0;
  logic [7:0] mem_rdata = 8'h00;
  logic [11:0] mem_addr;
  logic mem_indexed, mem_we, instr_ready, sw_reset_pulse;
  logic [7:0] mem_wdata;
  logic [snc_pkg::PC_W-1:0] pc, stack_top, epc, t;
  logic [4:0] stack_ptr, status_flags;
  logic [20:0] q[$];
  logic [20:0] e;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  integer seed = 32'hB7B9087D;

  // free-running 125 MHz clock
  always #4 clk = ~clk;

  snc_core i_dut (.clk(clk), .rstn(rstn), .instr(instr), .instr_valid(instr_valid),
    .ext_set_en(ext_set_en), .bank_sel_in(bank_sel_in), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .mem_indexed(mem_indexed), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .pc(pc), .stack_top(stack_top), .stack_ptr(stack_ptr),
    .status_flags(status_flags), .instr_ready(instr_ready),
    .sw_reset_pulse(sw_reset_pulse));

  // wide enough for the packed reset and software reset snapshots
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // present one word; it is taken at the next edge
  task automatic op(input logic [15:0] w, input logic [7:0] d, input logic [3:0] b,
                    input logic x);
    @(posedge clk);
    instr <= w;
    mem_rdata <= d;
    bank_sel_in <= b;
    ext_set_en <= x;
    instr_valid <= 1'b1;
  endtask

  // taking edge, then look once its updates have landed
  task automatic idle();
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  // hang guard, far above the roughly 90 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // each write strobe consumes the oldest noted write
  always @(posedge clk) if (rstn && mem_we === 1'b1) begin
    e = (q.size() > 0) ? q.pop_front() : 21'h1FFFFF;
    chk({mem_indexed, mem_indexed ? {4'h0, mem_addr[7:0]} : mem_addr, mem_wdata}, e);
  end

  initial begin
    logic [7:0] f, d, r;
    logic a, x, ix;
    logic [3:0] b;
    logic [10:0] n;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    #1 chk({pc, stack_ptr, status_flags, instr_ready}, 21'h1);
    epc = 0;
    op(snc_pkg::OP_PUSH, 0, 0, 0);
    op(snc_pkg::OP_PUSH, 0, 0, 0);
    idle();
    chk(stack_top, 4);
    chk(stack_ptr, 2);
    op(snc_pkg::OP_DISCARD, 0, 0, 0);
    idle();
    chk(stack_top, 2);
    chk(stack_ptr, 1);
    chk(pc, 6);
    // push then discard back to back: the old top must come back
    op(snc_pkg::OP_PUSH, 0, 0, 0);
    op(snc_pkg::OP_DISCARD, 0, 0, 0);
    idle();
    chk(stack_top, 2);
    chk(stack_ptr, 1);
    chk(pc, 10);
    epc = 10;
    $display("push and discard done");
    // boundaries of the indexed window and of the operand first, then random
    for (int i = 0; i < 24; i++) begin
      f = (i < 2) ? 8'(8'h5F + i) : 8'($random(seed));
      d = (i == 2) ? 8'h00 : (i == 3) ? 8'h80 : 8'($random(seed));
      a = (i < 2) ? 1'b0 : 1'($random(seed));
      x = (i < 2) ? 1'b1 : 1'($random(seed));
      b = 4'($random(seed));
      r = ~d + 8'h01;
      ix = x && !a && f <= 8'h5F;
      q.push_back({ix, a ? {b, f} : {(f >= 8'h80) ? 4'hF : 4'h0, f}, r});
      op({snc_pkg::OP_NEG_HI, a, f}, d, b, x);
      idle();
      epc = epc + 2;
      chk(status_flags, {r[7], d == 8'h80, r == 8'h00, d[3:0] == 4'h0, d == 8'h00});
      chk(pc, epc);
    end
    $display("negate done");
    for (int i = 0; i < 6; i++) begin
      n = (i == 0) ? 11'h400 : (i == 1) ? 11'h3FF : 11'($random(seed));
      t = epc + 2;
      epc = t + {{9{n[10]}}, n, 1'b0};
      op({snc_pkg::OP_CALL_HI, n}, 0, 0, 0);
      idle();
      chk(stack_top, t);
      chk(pc, epc);
      chk(instr_ready, 0);
      @(posedge clk);
      #1 chk(instr_ready, 1);
    end
    $display("relative call done");
    op(snc_pkg::OP_SWRESET, 0, 0, 0);
    idle();
    chk({pc, stack_ptr, status_flags, sw_reset_pulse}, 21'h1);
    @(posedge clk);
    #1 chk(sw_reset_pulse, 0);
    $display("software reset done");
    // every noted write must have been seen on the strobe
    chk(q.size(), 0);
    print_verdict();
  end
endmodule
